// [verilog/ctd_core.sv]
`timescale 1ns/1ps
module ctd_core #(
  parameter logic [15:0] START_ADDR = 16'h0000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // memory bus
  output ctd_pkg::ctd_bus_s mem_bus,
  input wire logic [7:0] mem_rdata,
  // interrupt logic and mode
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic test_mode,
  // status
  output ctd_pkg::ctd_regs_s cpu_regs,
  output logic instr_done,
  output logic illegal_op,
  output logic waiting,
  // operand formatter
  input wire logic fmt_req,
  input wire ctd_pkg::ctd_fmt_e fmt_sel,
  input wire logic [7:0] fmt_b0,
  input wire logic [7:0] fmt_b1,
  input wire logic [15:0] fmt_base,
  output logic fmt_valid,
  output logic [15:0] fmt_value
);
  import ctd_pkg::*;

  localparam logic [15:0] START_NEXT = START_ADDR + 16'h0001;

  ctd_state_e st_q, st_d;
  logic [3:0] step_q, step_d;
  logic pre_q, pre_d;
  logic [7:0] op_q, op_d;
  logic [7:0] hi_q, hi_d;
  logic [15:0] vec_q, vec_d;
  ctd_bus_s bus_q, bus_d;
  ctd_regs_s regs_q, regs_d;
  logic done_q, done_d;
  logic ill_q, ill_d;
  logic wait_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic in_run, pre_fetch, at_op, op_bad, is_stack, is_test, is_last;
  logic is_ext, is_idx, mem_step;
  logic [3:0] op_step, rel_step, last_step;
  logic [7:0] cur_op, push_byte;
  logic [15:0] idx_sel;
  logic [71:0] push_vec;

  // the opcode is read straight off the bus in its own cycle, later from op_q
  assign in_run = st_q == ST_RUN;
  assign pre_fetch = in_run && step_q == 4'h0 && mem_rdata == OP_PRE;
  assign op_step = {3'b000, pre_q};
  assign at_op = in_run && step_q == op_step && !pre_fetch;
  assign cur_op = at_op ? mem_rdata : op_q;
  assign rel_step = step_q - op_step;
  // unknown opcodes, bad prefixes and 00 outside test mode run as short no-ops
  assign op_bad = !f_known(cur_op) || (pre_q && !f_pre_ok(cur_op)) || (cur_op == OP_TEST && !test_mode);
  assign is_stack = !op_bad && (cur_op == OP_TRAP || cur_op == OP_IDLE);
  assign is_test = !op_bad && cur_op == OP_TEST;
  assign is_ext = !op_bad && cur_op == OP_ZCHK_EXT;
  assign is_idx = !op_bad && cur_op == OP_ZCHK_IDX;
  assign last_step = (op_bad ? CYC_INH - 4'h1 : f_last(cur_op)) + op_step;
  assign is_last = in_run && !pre_fetch && !is_stack && !is_test && step_q == last_step;
  // operand byte comes back three or two steps after the opcode
  assign mem_step = in_run && ((is_ext && rel_step == 4'h3) || (is_idx && rel_step == 4'h2));
  assign idx_sel = pre_q ? regs_q.y : regs_q.x;

  // stacking order, low byte of the return address first
  assign push_vec = {regs_q.flags, regs_q.b, regs_q.a, regs_q.x, regs_q.y, regs_q.pc};
  assign push_byte = push_vec[{step_q, 3'b000} +: 8];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // pc always points at the next instruction-stream byte, so a fetch
  // issued now bumps it and the stacked return address is simply pc
  always_comb begin
    st_d = st_q;
    step_d = step_q + 4'h1;
    pre_d = pre_q;
    op_d = op_q;
    hi_d = hi_q;
    vec_d = vec_q;
    bus_d = '{addr: bus_q.addr, rd: 1'b0, wr: 1'b0, wdata: 8'h00};
    regs_d = regs_q;
    done_d = 1'b0;
    ill_d = 1'b0;
    unique case (st_q)
      ST_RUN: begin
        if (pre_fetch) begin
          pre_d = 1'b1;
          bus_d = f_rd(regs_q.pc);
          regs_d.pc = regs_q.pc + 16'h0001;
        end else begin
          if (at_op) begin
            op_d = mem_rdata;
            ill_d = op_bad;
          end
          if (is_stack && step_q <= PUSH_LAST) begin
            bus_d = f_wr(regs_q.sp, push_byte);
            regs_d.sp = regs_q.sp - 16'h0001;
          end
          if ((is_ext && rel_step <= 4'h1) || (is_idx && rel_step == 4'h0)) begin
            bus_d = f_rd(regs_q.pc);
            regs_d.pc = regs_q.pc + 16'h0001;
          end
          if (is_ext && rel_step == 4'h1) begin
            hi_d = mem_rdata;
          end
          if (is_ext && rel_step == 4'h2) begin
            bus_d = f_rd(f_extended(hi_q, mem_rdata));
          end
          if (is_idx && rel_step == 4'h1) begin
            bus_d = f_rd(f_indexed(idx_sel, mem_rdata));
          end
          if (mem_step) begin
            regs_d.flags = f_nz(regs_q.flags, mem_rdata, 1'b1);
          end
          if (is_test && at_op) begin
            st_d = ST_TEST;
            bus_d = f_rd(regs_q.pc);
          end
          if (is_stack && step_q == STACK_END) begin
            if (cur_op == OP_IDLE) begin
              st_d = ST_WAIT;
              step_d = step_q;
            end else begin
              st_d = ST_VEC;
              vec_d = TRAP_VEC;
              bus_d = f_rd(TRAP_VEC);
            end
          end
          if (is_last) begin
            if (!op_bad) begin
              case (cur_op)
                OP_TAP: begin
                  regs_d.flags = regs_q.a;
                  regs_d.flags[CC_X] = f_clear_only(regs_q.flags[CC_X], regs_q.a[CC_X]);
                end
                OP_FLAGS_A: regs_d.a = regs_q.flags;
                OP_TAB: begin
                  regs_d.b = regs_q.a;
                  regs_d.flags = f_nz(regs_q.flags, regs_q.a, 1'b0);
                end
                OP_B_TO_A: begin
                  regs_d.a = regs_q.b;
                  regs_d.flags = f_nz(regs_q.flags, regs_q.b, 1'b0);
                end
                OP_ZCHK_A: regs_d.flags = f_nz(regs_q.flags, regs_q.a, 1'b1);
                OP_ZCHK_B: regs_d.flags = f_nz(regs_q.flags, regs_q.b, 1'b1);
                OP_SP_TO_IDX: begin
                  if (pre_q) begin
                    regs_d.y = regs_q.sp + 16'h0001;
                  end else begin
                    regs_d.x = regs_q.sp + 16'h0001;
                  end
                end
                OP_IDX_TO_SP: regs_d.sp = idx_sel - 16'h0001;
                OP_XGD: begin
                  {regs_d.a, regs_d.b} = idx_sel;
                  if (pre_q) begin
                    regs_d.y = {regs_q.a, regs_q.b};
                  end else begin
                    regs_d.x = {regs_q.a, regs_q.b};
                  end
                end
                default: regs_d = regs_q;
              endcase
            end
            bus_d = f_rd(regs_q.pc);
            regs_d.pc = regs_q.pc + 16'h0001;
            step_d = 4'h0;
            pre_d = 1'b0;
            done_d = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        step_d = step_q;
        if (irq_req) begin
          st_d = ST_VEC;
          step_d = VEC_HI;
          vec_d = irq_vector;
          bus_d = f_rd(irq_vector);
        end
      end
      ST_VEC: begin
        if (step_q == VEC_HI) begin
          hi_d = mem_rdata;
          bus_d = f_rd(vec_q + 16'h0001);
        end else begin
          bus_d = f_rd({hi_q, mem_rdata});
          regs_d.pc = {hi_q, mem_rdata} + 16'h0001;
          regs_d.flags[CC_I] = 1'b1;
          st_d = ST_RUN;
          step_d = 4'h0;
          pre_d = 1'b0;
          done_d = 1'b1;
        end
      end
      ST_TEST: begin
        // only reset leaves this state
        step_d = step_q;
        bus_d = f_rd(bus_q.addr + 16'h0001);
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // reset presents the first fetch at once, so the bus is never idle garbage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_RUN;
      step_q <= 4'h0;
      pre_q <= 1'b0;
      op_q <= 8'h00;
      hi_q <= 8'h00;
      vec_q <= 16'h0000;
      bus_q <= '{addr: START_ADDR, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      regs_q <= '{pc: START_NEXT, sp: 16'h0000, x: 16'h0000, y: 16'h0000, a: 8'h00, b: 8'h00, flags: FLAGS_RESET};
      wait_q <= 1'b0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      st_q <= st_d;
      step_q <= step_d;
      pre_q <= pre_d;
      op_q <= op_d;
      hi_q <= hi_d;
      vec_q <= vec_d;
      bus_q <= bus_d;
      regs_q <= regs_d;
      wait_q <= st_d == ST_WAIT;
      done_q <= done_d;
      ill_q <= ill_d;
    end
  end

  // outputs straight from flops
  assign mem_bus = bus_q;
  assign cpu_regs = regs_q;
  assign instr_done = done_q;
  assign illegal_op = ill_q;
  assign waiting = wait_q;

  // ----------------------------------------------------------------
  // operand formatter
  // ----------------------------------------------------------------
  ctd_opnd_fmt u_fmt (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .req(fmt_req),
    .fmt(fmt_sel),
    .b0(fmt_b0),
    .b1(fmt_b1),
    .base(fmt_base),
    .valid_q(fmt_valid),
    .value_q(fmt_value)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic fetch0, exec_ok;
  assign fetch0 = in_run && step_q == 4'h0;
  assign exec_ok = is_last && !op_bad;

  property p_tap_len;
    fetch0 && mem_rdata == OP_TAP |-> ##2 instr_done;
  endproperty
  a_tap_len: assert property (p_tap_len) else $error("06 not done in two cycles");

  property p_tap_x;
    exec_ok && cur_op == OP_TAP && !regs_q.flags[CC_X] |=> !regs_q.flags[CC_X];
  endproperty
  a_tap_x: assert property (p_tap_x) else $error("x mask was set");

  property p_flags_a;
    exec_ok && cur_op == OP_FLAGS_A |=> regs_q.a == $past(regs_q.flags) && $stable(regs_q.flags);
  endproperty
  a_flags_a: assert property (p_flags_a) else $error("flags copy to a wrong");

  property p_test;
    st_q == ST_TEST |=> st_q == ST_TEST && mem_bus.addr == $past(mem_bus.addr) + 16'h0001;
  endproperty
  a_test: assert property (p_test) else $error("test address not counting");

  // the fetch cycle itself carries the previous instruction's done pulse
  property p_zchk_ext;
    fetch0 && mem_rdata == OP_ZCHK_EXT |-> ##1 !instr_done [*5] ##1 instr_done;
  endproperty
  a_zchk_ext: assert property (p_zchk_ext) else $error("7D length wrong");

  property p_zchk_a;
    exec_ok && cur_op == OP_ZCHK_A |=> regs_q.flags[1:0] == 2'b00 && regs_q.flags[CC_Z] == ($past(regs_q.a) == 8'h00);
  endproperty
  a_zchk_a: assert property (p_zchk_a) else $error("a test flags wrong");

  property p_sp_to_x;
    exec_ok && cur_op == OP_SP_TO_IDX && !pre_q |=> regs_q.x == $past(regs_q.sp) + 16'h0001 && $stable(regs_q.flags);
  endproperty
  a_sp_to_x: assert property (p_sp_to_x) else $error("x not stack plus one");

  property p_y_to_sp;
    exec_ok && cur_op == OP_IDX_TO_SP && pre_q |=> regs_q.sp == $past(regs_q.y) - 16'h0001;
  endproperty
  a_y_to_sp: assert property (p_y_to_sp) else $error("stack not y minus one");

  property p_idle;
    fetch0 && mem_rdata == OP_IDLE |-> ##12 waiting;
  endproperty
  a_idle: assert property (p_idle) else $error("wait not after twelve cycles");

  property p_trap;
    fetch0 && mem_rdata == OP_TRAP |-> ##14 instr_done && regs_q.flags[CC_I];
  endproperty
  a_trap: assert property (p_trap) else $error("3F not done in fourteen");

  property p_swap_x;
    exec_ok && cur_op == OP_XGD && !pre_q |=> {regs_q.a, regs_q.b} == $past(regs_q.x) && regs_q.x[7:0] == $past(regs_q.b);
  endproperty
  a_swap_x: assert property (p_swap_x) else $error("d and x not swapped");
endmodule

// [pkg/ctd_pkg.sv]
package ctd_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PRE = 8'h18;
  localparam logic [7:0] OP_TEST = 8'h00;
  localparam logic [7:0] OP_TAP = 8'h06;
  localparam logic [7:0] OP_FLAGS_A = 8'h07;
  localparam logic [7:0] OP_TAB = 8'h16;
  localparam logic [7:0] OP_B_TO_A = 8'h17;
  localparam logic [7:0] OP_SP_TO_IDX = 8'h30;
  localparam logic [7:0] OP_IDX_TO_SP = 8'h35;
  localparam logic [7:0] OP_IDLE = 8'h3E;
  localparam logic [7:0] OP_TRAP = 8'h3F;
  localparam logic [7:0] OP_ZCHK_A = 8'h4D;
  localparam logic [7:0] OP_ZCHK_B = 8'h5D;
  localparam logic [7:0] OP_ZCHK_IDX = 8'h6D;
  localparam logic [7:0] OP_ZCHK_EXT = 8'h7D;
  localparam logic [7:0] OP_XGD = 8'h8F;

  // ----------------------------------------------------------------
  // cycle counts, one bus cycle per sys_clk edge
  // ----------------------------------------------------------------
  localparam logic [3:0] CYC_INH = 4'h2;
  localparam logic [3:0] CYC_XFER = 4'h3;
  localparam logic [3:0] CYC_ZCHK = 4'h6;
  localparam logic [3:0] PUSH_LAST = 4'h8;
  localparam logic [3:0] STACK_END = 4'hB;
  localparam logic [3:0] VEC_HI = 4'hC;
  localparam logic [15:0] TRAP_VEC = 16'hFFF6;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // flag positions
  localparam int CC_X = 6;
  localparam int CC_I = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_VEC = 2'b10,
    ST_TEST = 2'b11
  } ctd_state_e;

  typedef enum logic [2:0] {
    FMT_DIR = 3'b000,
    FMT_IDX = 3'b001,
    FMT_EXT = 3'b010,
    FMT_IMM8 = 3'b011,
    FMT_IMM16 = 3'b100,
    FMT_MASK = 3'b101,
    FMT_REL = 3'b110
  } ctd_fmt_e;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } ctd_bus_s;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] x;
    logic [15:0] y;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] flags;
  } ctd_regs_s;

  // ----------------------------------------------------------------
  // shared functions
  // ----------------------------------------------------------------
  function automatic ctd_bus_s f_rd(input logic [15:0] addr);
    return '{addr: addr, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
  endfunction

  function automatic ctd_bus_s f_wr(input logic [15:0] addr, input logic [7:0] data);
    return '{addr: addr, rd: 1'b0, wr: 1'b1, wdata: data};
  endfunction

  // high byte of a direct address is always zero
  function automatic logic [15:0] f_direct(input logic [7:0] lo);
    return {8'h00, lo};
  endfunction

  // unsigned offset, no sign extension
  function automatic logic [15:0] f_indexed(input logic [15:0] base, input logic [7:0] off);
    return base + {8'h00, off};
  endfunction

  // high byte comes first on the bus
  function automatic logic [15:0] f_extended(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

  // base is the address after the offset byte
  function automatic logic [15:0] f_relative(input logic [15:0] base, input logic [7:0] off);
    return base + {{8{off[7]}}, off};
  endfunction

  // a clear-only flag may fall but never rise
  function automatic logic f_clear_only(input logic old_v, input logic new_v);
    return old_v & new_v;
  endfunction

  // n and z from a byte, v cleared, c optionally cleared
  function automatic logic [7:0] f_nz(input logic [7:0] flg, input logic [7:0] v, input logic clr_c);
    return {flg[7:4], v[7], v == 8'h00, 1'b0, clr_c ? 1'b0 : flg[CC_C]};
  endfunction

  function automatic logic f_known(input logic [7:0] op);
    return op inside {OP_TEST, OP_TAP, OP_FLAGS_A, OP_TAB, OP_B_TO_A, OP_SP_TO_IDX, OP_IDX_TO_SP, OP_IDLE, OP_TRAP,
                      OP_ZCHK_A, OP_ZCHK_B, OP_ZCHK_IDX, OP_ZCHK_EXT, OP_XGD};
  endfunction

  function automatic logic f_pre_ok(input logic [7:0] op);
    return op inside {OP_SP_TO_IDX, OP_IDX_TO_SP, OP_ZCHK_IDX, OP_XGD};
  endfunction

  // last step counted from the opcode byte
  function automatic logic [3:0] f_last(input logic [7:0] op);
    case (op)
      OP_ZCHK_EXT, OP_ZCHK_IDX: return CYC_ZCHK - 4'h1;
      OP_SP_TO_IDX, OP_IDX_TO_SP, OP_XGD: return CYC_XFER - 4'h1;
      default: return CYC_INH - 4'h1;
    endcase
  endfunction

endpackage

// [verilog/ctd_opnd_fmt.sv]
`timescale 1ns/1ps
module ctd_opnd_fmt (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // request
  input wire logic req,
  input wire ctd_pkg::ctd_fmt_e fmt,
  input wire logic [7:0] b0,
  input wire logic [7:0] b1,
  input wire logic [15:0] base,
  // answer
  output logic valid_q,
  output logic [15:0] value_q
);
  import ctd_pkg::*;

  // ----------------------------------------------------------------
  // operand decode
  // ----------------------------------------------------------------
  logic [15:0] value_d;
  assign value_d = (fmt == FMT_DIR) ? f_direct(b0) :
                   (fmt == FMT_IDX) ? f_indexed(base, b0) :
                   (fmt == FMT_EXT) ? f_extended(b0, b1) :
                   (fmt == FMT_IMM16) ? {b0, b1} :
                   (fmt == FMT_MASK) ? {b0, base[7:0] & b0} :
                   (fmt == FMT_REL) ? f_relative(base, b0) :
                   {8'h00, b0};

  // result registered one cycle after the request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      valid_q <= 1'b0;
      value_q <= 16'h0000;
    end else begin
      valid_q <= req;
      value_q <= req ? value_d : value_q;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_direct;
    req && fmt == FMT_DIR |=> valid_q && value_q == {8'h00, $past(b0)};
  endproperty
  a_direct: assert property (p_direct) else $error("direct high byte not zero");

  property p_rel;
    req && fmt == FMT_REL && b0[7] |=> value_q == $past(base) - {8'h00, 8'h00 - $past(b0)};
  endproperty
  a_rel: assert property (p_rel) else $error("negative branch offset wrong");
endmodule

// [bench/ctd_mem_model.sv]
`timescale 1ns/1ps
module ctd_mem_model (
  // clock
  input wire logic sys_clk,
  // bus from the core
  input wire ctd_pkg::ctd_bus_s mem_bus,
  output logic [7:0] mem_rdata
);
  import ctd_pkg::*;

  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;

  // zero-latency read; an idle cycle shows the inverted last byte so stale data never passes
  assign mem_rdata = mem_bus.rd ? mem[mem_bus.addr] : ~last_q;

  // writes land on the edge that closes the access
  always @(posedge sys_clk) begin
    if (mem_bus.wr) begin
      mem[mem_bus.addr] <= mem_bus.wdata;
    end
    if (mem_bus.rd) begin
      last_q <= mem[mem_bus.addr];
    end
  end
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  import ctd_pkg::*;

  logic sys_clk;
  logic rstn;
  ctd_bus_s mem_bus;
  logic [7:0] mem_rdata;
  logic irq_req;
  logic [15:0] irq_vector;
  logic test_mode;
  ctd_regs_s cpu_regs;
  logic instr_done;
  logic illegal_op;
  logic waiting;
  logic fmt_req;
  ctd_fmt_e fmt_sel;
  logic [7:0] fmt_b0;
  logic [7:0] fmt_b1;
  logic [15:0] fmt_base;
  logic fmt_valid;
  logic [15:0] fmt_value;
  int bad_count = 0;
  int checked = 0;

  ctd_core dut (
    .sys_clk(sys_clk), .rstn(rstn), .mem_bus(mem_bus), .mem_rdata(mem_rdata),
    .irq_req(irq_req), .irq_vector(irq_vector), .test_mode(test_mode),
    .cpu_regs(cpu_regs), .instr_done(instr_done), .illegal_op(illegal_op), .waiting(waiting),
    .fmt_req(fmt_req), .fmt_sel(fmt_sel), .fmt_b0(fmt_b0), .fmt_b1(fmt_b1),
    .fmt_base(fmt_base), .fmt_valid(fmt_valid), .fmt_value(fmt_value)
  );

  ctd_mem_model mem_i (.sys_clk(sys_clk), .mem_bus(mem_bus), .mem_rdata(mem_rdata));

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic prog(input logic [15:0] at, input logic [7:0] b[]);
    foreach (b[i]) mem_i.mem[at + 16'(i)] = b[i];
  endtask

  // counts cycles up to the done pulse, then checks next fetch and registers
  task automatic op(input int n, input logic [15:0] f, input logic [15:0] d, input logic [7:0] c,
                    input logic [15:0] x, input logic [15:0] y, input logic [15:0] s);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (instr_done !== 1'b1 && k < 40);
    chk(16'(k), 16'(n));
    chk(mem_bus.addr, f);
    chk({cpu_regs.a, cpu_regs.b}, d);
    chk({8'h00, cpu_regs.flags}, {8'h00, c});
    chk(cpu_regs.x, x);
    chk(cpu_regs.y, y);
    chk(cpu_regs.sp, s);
  endtask

  // ----------------------------------------------------------------
  // scenarios, in program order
  // ----------------------------------------------------------------
  task automatic s_flags_a();
    op(6, 16'h0003, 16'h0000, 8'h08, 16'h0000, 16'h0000, 16'h0000);
    op(2, 16'h0004, 16'h0800, 8'h08, 16'h0000, 16'h0000, 16'h0000);
    op(2, 16'h0005, 16'h0808, 8'h00, 16'h0000, 16'h0000, 16'h0000);
  endtask

  task automatic s_swap_stack();
    op(3, 16'h0006, 16'h0000, 8'h00, 16'h0808, 16'h0000, 16'h0000);
    op(3, 16'h0007, 16'h0000, 8'h00, 16'h0808, 16'h0000, 16'h0807);
    op(4, 16'h0009, 16'h0000, 8'h00, 16'h0808, 16'h0808, 16'h0807);
  endtask

  task automatic s_zero_tests();
    op(6, 16'h000B, 16'h0000, 8'h04, 16'h0808, 16'h0808, 16'h0807);
    op(7, 16'h000E, 16'h0000, 8'h08, 16'h0808, 16'h0808, 16'h0807);
    op(2, 16'h000F, 16'h0000, 8'h04, 16'h0808, 16'h0808, 16'h0807);
    op(2, 16'h0010, 16'h0000, 8'h04, 16'h0808, 16'h0808, 16'h0807);
  endtask

  task automatic s_index_y();
    op(4, 16'h0012, 16'h0808, 8'h04, 16'h0808, 16'h0000, 16'h0807);
    op(2, 16'h0013, 16'h0808, 8'h00, 16'h0808, 16'h0000, 16'h0807);
    op(4, 16'h0015, 16'h0808, 8'h00, 16'h0808, 16'h0000, 16'hFFFF);
    op(3, 16'h0016, 16'h0808, 8'h00, 16'h0000, 16'h0000, 16'hFFFF);
  endtask

  // vector low byte is the stacked flag byte, so the target proves the push order
  task automatic s_trap();
    op(14, 16'h0300, 16'h0808, 8'h10, 16'h0000, 16'h0000, 16'hFFF6);
    chk({8'h00, mem_i.mem[16'hFFFF]}, 16'h0017);
    chk({8'h00, mem_i.mem[16'hFFF9]}, 16'h0008);
  endtask

  task automatic s_clear_only();
    op(3, 16'h0301, 16'h0808, 8'h10, 16'hFFF7, 16'h0000, 16'hFFF6);
    op(3, 16'h0302, 16'hFFF7, 8'h10, 16'h0808, 16'h0000, 16'hFFF6);
    op(2, 16'h0303, 16'hFFF7, 8'hBF, 16'h0808, 16'h0000, 16'hFFF6);
    op(2, 16'h0304, 16'hBFF7, 8'hBF, 16'h0808, 16'h0000, 16'hFFF6);
  endtask

  // interrupt comes in the third wait cycle, so the total is 14 + 3
  task automatic s_wait();
    int n;
    n = 0;
    irq_vector = 16'h0400;
    while (waiting !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(16'(n), 16'h000C);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({15'h0000, waiting}, 16'h0001);
    irq_req = 1'b1;
    @(posedge sys_clk);
    #1;
    irq_req = 1'b0;
    op(2, 16'h0500, 16'hBFF7, 8'hBF, 16'h0808, 16'h0000, 16'hFFED);
  endtask

  task automatic s_test_mode();
    for (int i = 1; i < 8; i++) begin
      @(posedge sys_clk);
      #1;
      chk(mem_bus.addr, 16'h0500 + 16'(i));
    end
  endtask

  // back to back requests through every operand format
  task automatic fmt(input ctd_fmt_e s, input logic [7:0] b0, input logic [7:0] b1,
                     input logic [15:0] base, input logic [15:0] exp);
    fmt_sel = s;
    fmt_b0 = b0;
    fmt_b1 = b1;
    fmt_base = base;
    fmt_req = 1'b1;
    @(posedge sys_clk);
    #1;
    chk({15'h0000, fmt_valid}, 16'h0001);
    chk(fmt_value, exp);
  endtask

  task automatic s_format();
    fmt(FMT_DIR, 8'hA5, 8'h00, 16'h1234, 16'h00A5);
    fmt(FMT_IDX, 8'hFF, 8'h00, 16'hFFF0, 16'h00EF);
    fmt(FMT_IDX, 8'h80, 8'h00, 16'h1000, 16'h1080);
    fmt(FMT_EXT, 8'h12, 8'h34, 16'h0000, 16'h1234);
    fmt(FMT_IMM8, 8'h5A, 8'h77, 16'h0000, 16'h005A);
    fmt(FMT_IMM16, 8'hAB, 8'hCD, 16'h0000, 16'hABCD);
    fmt(FMT_MASK, 8'h3C, 8'h00, 16'h00F0, 16'h3C30);
    fmt(FMT_REL, 8'h80, 8'h00, 16'h1000, 16'h0F80);
    fmt(FMT_REL, 8'h7F, 8'h00, 16'h1000, 16'h107F);
    fmt_req = 1'b0;
  endtask

  // second reset: 00 without test mode and a bad prefix run as no-ops
  task automatic s_illegal();
    test_mode = 1'b0;
    prog(16'h0000, '{8'h00, 8'h18, 8'h4D});
    @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    @(posedge sys_clk);
    #1;
    chk({15'h0000, illegal_op}, 16'h0001);
    op(1, 16'h0001, 16'h0000, 8'h00, 16'h0000, 16'h0000, 16'h0000);
    op(3, 16'h0003, 16'h0000, 8'h00, 16'h0000, 16'h0000, 16'h0000);
  endtask

  task automatic results();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    irq_req = 1'b0;
    irq_vector = 16'h0000;
    test_mode = 1'b1;
    fmt_req = 1'b0;
    fmt_sel = FMT_DIR;
    fmt_b0 = 8'h00;
    fmt_b1 = 8'h00;
    fmt_base = 16'h0000;
    prog(16'h0000, '{8'h7D, 8'h20, 8'h00, 8'h07, 8'h16, 8'h8F, 8'h35, 8'h18, 8'h30, 8'h6D, 8'h10,
                     8'h18, 8'h6D, 8'h01, 8'h4D, 8'h17, 8'h18, 8'h8F, 8'h5D, 8'h18, 8'h35, 8'h30, 8'h3F});
    prog(16'h0300, '{8'h30, 8'h8F, 8'h06, 8'h07, 8'h3E});
    prog(16'h0400, '{8'h05, 8'h00});
    prog(16'h0500, '{8'h00});
    prog(16'h2000, '{8'h80});
    prog(16'h0809, '{8'hFF});
    prog(16'h0818, '{8'h00});
    prog(16'hFFF6, '{8'h03});
    repeat (12) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    s_flags_a();
    s_swap_stack();
    s_zero_tests();
    s_index_y();
    s_trap();
    s_clear_only();
    s_wait();
    s_test_mode();
    s_format();
    // only reset ends the counting mode
    rstn = 1'b0;
    #2;
    chk(mem_bus.addr, 16'h0000);
    s_illegal();
    results();
  end

  // a hang is cut short well past the roughly 125 cycles the run needs
  initial begin
    #20000;
    bad_count++;
    results();
  end
endmodule
